/* File: mtu_pkg.sv */
// What this block does
// - General timers pick fast, slow or wake underflow clock.
// - Sixteen-bit counter and reload, high and low bytes.
// - Wake timer counts low-frequency oscillator ticks.
// - Shared control starts and stops four timers, reports all five.
// - Running counter decrements once per selected tick.
// - Zero count plus next tick raises enabled interrupt.
// - Enabled timer interrupt drives the request pin.
// - Software can set and clear each flag.
// - Underflow halts at zero or reloads per setting.
// - Running bit set while counting, clear when stopped.
// - Run and immediate bits together start; immediate alone stops.
// - Start bit in timer control also starts it.
// - Armed timer waits for its start event.
// - Stop event before underflow halts without interrupt.
// - Wake timer leaves standby; may return without card.
// - Auto-wake clear keeps device powered after wake.
// - Auto-reload with enable gives periodic interrupts.
// - Underflow sets flag in second interrupt register.
package mtu_pkg;
  localparam int unsigned NTMR = 5;
  localparam int unsigned WAKE_IDX = 4;
  // Byte addresses of the shared registers.
  localparam logic [7:0] ADR_RUN_CTL = 8'h00;
  localparam logic [7:0] ADR_IRQ_FLG = 8'h04;
  localparam logic [7:0] ADR_IRQ_EN  = 8'h08;
  localparam logic [7:0] ADR_PWR     = 8'h0c;
  // Per-timer window: base is TMR_STRIDE * (index + 1).
  localparam logic [7:0] TMR_STRIDE  = 8'h20;
  localparam logic [2:0] OFS_CTL     = 3'h0;
  localparam logic [2:0] OFS_REL_HI  = 3'h1;
  localparam logic [2:0] OFS_REL_LO  = 3'h2;
  localparam logic [2:0] OFS_CNT_HI  = 3'h3;
  localparam logic [2:0] OFS_CNT_LO  = 3'h4;
  // Timer control fields.
  localparam int unsigned CTL_CLK_LSB  = 0;
  localparam int unsigned CTL_AUTO_REL = 2;
  localparam int unsigned CTL_START    = 3;
  localparam int unsigned CTL_WAIT_EVT = 4;
  localparam int unsigned CTL_STOP_EVT = 5;
  localparam int unsigned CTL_AUTO_WK  = 6;
  localparam int unsigned CTL_W        = 7;
  localparam int unsigned SSN_LSB      = 4;
  localparam int unsigned FLG_SET_BIT  = 7;
  localparam logic [1:0] CLK_FAST = 2'h0;
  localparam logic [1:0] CLK_SLOW = 2'h1;
  localparam logic [1:0] CLK_WAKE = 2'h2;
  // Reset values.
  localparam logic [6:0]  CTL_RST = 7'h00;
  localparam logic [15:0] REL_RST = 16'hffff;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    MTU_IDLE  = 2'b00,
    MTU_ARMED = 2'b01,
    MTU_RUN   = 2'b10
  } mtu_state_e;
endpackage

/* File: mtu_chan.sv */
`timescale 1ns/1ps
module mtu_chan (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Commands and events.
  input  wire logic        tick_in,
  input  wire logic        start_in,
  input  wire logic        stop_in,
  input  wire logic        start_evt_in,
  input  wire logic        stop_evt_in,
  // Settings.
  input  wire logic        wait_evt_in,
  input  wire logic        stop_evt_en_in,
  input  wire logic        auto_reload_in,
  input  wire logic [15:0] reload_in,
  // Status.
  output logic      [15:0] count_out,
  output logic             running_out,
  output logic             underflow_out
);
  typedef struct packed {
    mtu_pkg::mtu_state_e st;
    logic [15:0]         cnt;
    logic                unf;
  } mtu_chan_s;
  mtu_chan_s s_r, s_nxt;

  // One decision per clock; commands beat events, events beat ticks.
  always_comb begin
    s_nxt = s_r;
    s_nxt.unf = 1'b0;
    if (stop_in) begin
      s_nxt.st = mtu_pkg::MTU_IDLE;
    end else if (start_in) begin
      s_nxt.cnt = reload_in;
      s_nxt.st = wait_evt_in ? mtu_pkg::MTU_ARMED : mtu_pkg::MTU_RUN;
    end else begin
      case (s_r.st)
        mtu_pkg::MTU_ARMED: begin
          if (start_evt_in) begin
            s_nxt.st = mtu_pkg::MTU_RUN;
          end
        end
        mtu_pkg::MTU_RUN: begin
          if (stop_evt_en_in && stop_evt_in) begin
            s_nxt.st = mtu_pkg::MTU_IDLE;
          end else if (tick_in) begin
            if (s_r.cnt == 16'h0000) begin
              s_nxt.unf = 1'b1;
              if (auto_reload_in) begin
                s_nxt.cnt = reload_in;
              end else begin
                s_nxt.st = mtu_pkg::MTU_IDLE;
              end
            end else begin
              s_nxt.cnt = s_r.cnt - 16'h0001;
            end
          end
        end
        default: s_nxt.st = mtu_pkg::MTU_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '{mtu_pkg::MTU_IDLE, mtu_pkg::CNT_RST, 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count_out     = s_r.cnt;
  assign running_out   = (s_r.st != mtu_pkg::MTU_IDLE);
  assign underflow_out = s_r.unf;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire quiet = !start_in && !stop_in && !(stop_evt_en_in && stop_evt_in);

  property p_dec;
    s_r.st == mtu_pkg::MTU_RUN && tick_in && quiet && s_r.cnt != 16'h0000
      |=> s_r.cnt == $past(s_r.cnt) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("count did not step down");
  property p_load;
    start_in && !stop_in |=> s_r.cnt == $past(reload_in) && running_out;
  endproperty
  a_load: assert property (p_load) else $error("start did not load");
  property p_halt;
    underflow_out && !$past(auto_reload_in) |-> !running_out && s_r.cnt == 16'h0000;
  endproperty
  a_halt: assert property (p_halt) else $error("timer did not halt");
  property p_stopevt;
    s_r.st == mtu_pkg::MTU_RUN && stop_evt_en_in && stop_evt_in && !start_in
      |=> !running_out && !underflow_out;
  endproperty
  a_stopevt: assert property (p_stopevt) else $error("stop event ignored");
endmodule

/* File: mtu_top.sv */
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module mtu_top (
  // Clock and reset.
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  // AHB-Lite slave.
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Timer clock ticks, one cycle each.
  input  wire logic        fast_tick_in,
  input  wire logic        slow_tick_in,
  input  wire logic        low_freq_osc_tick_in,
  // Protocol start and stop events per timer.
  input  wire logic [4:0]  start_evt_in,
  input  wire logic [4:0]  stop_evt_in,
  // Low power card detect handshake.
  input  wire logic        card_check_done_in,
  input  wire logic        card_found_in,
  // Outputs to the system.
  output logic             irq_out,
  output logic             standby_out,
  output logic             wake_out
);
  localparam int unsigned N = mtu_pkg::NTMR;
  localparam int unsigned W = mtu_pkg::WAKE_IDX;

  typedef struct packed {
    logic [N-1:0][mtu_pkg::CTL_W-1:0] ctl;
    logic [N-1:0][15:0]               rel;
    logic [N-1:0]                     flg;
    logic [N-1:0]                     ien;
    logic [N-1:0]                     st_p;
    logic [N-1:0]                     sp_p;
    logic                             stby;
    logic                             wake;
    logic                             irq;
    logic                             dph;
    logic [7:0]                       dadr;
    logic [31:0]                      rdata;
    logic                             ready;
  } mtu_top_s;
  mtu_top_s s_r, s_nxt;

  // Reset is released through two flops; assertion stays asynchronous.
  logic rst_m_r;
  logic rst_n;
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_m_r <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n   <= rst_m_r;
    end
  end

  logic [N-1:0][15:0] cnt;
  logic [N-1:0]       run;
  logic [N-1:0]       unf;
  logic [N-1:0]       tick;

  // Timer index of an address in a timer window, or N when none.
  function automatic logic [2:0] tmr_of(input logic [7:0] a);
    logic [2:0] blk;
    blk = a[7:5];
    if (blk == 3'h0 || blk > 3'(N)) begin
      tmr_of = 3'(N);
    end else begin
      tmr_of = blk - 3'h1;
    end
  endfunction

  // Register read value, captured in the address phase.
  function automatic logic [31:0] rd_word(input logic [7:0] a, input mtu_top_s s,
                                          input logic [N-1:0][15:0] c,
                                          input logic [N-1:0] r);
    logic [2:0] t;
    rd_word = mtu_pkg::RD_ZERO;
    t = tmr_of(a);
    if (t != 3'(N)) begin
      case (a[4:2])
        mtu_pkg::OFS_CTL:    rd_word = {25'h0, s.ctl[t] & 7'h77};
        mtu_pkg::OFS_REL_HI: rd_word = {24'h0, s.rel[t][15:8]};
        mtu_pkg::OFS_REL_LO: rd_word = {24'h0, s.rel[t][7:0]};
        mtu_pkg::OFS_CNT_HI: rd_word = {24'h0, c[t][15:8]};
        mtu_pkg::OFS_CNT_LO: rd_word = {24'h0, c[t][7:0]};
        default:             rd_word = mtu_pkg::RD_ZERO;
      endcase
    end else begin
      case (a)
        mtu_pkg::ADR_RUN_CTL: rd_word = {27'h0, r};
        mtu_pkg::ADR_IRQ_FLG: rd_word = {27'h0, s.flg};
        mtu_pkg::ADR_IRQ_EN:  rd_word = {27'h0, s.ien};
        mtu_pkg::ADR_PWR:     rd_word = {31'h0, s.stby};
        default:              rd_word = mtu_pkg::RD_ZERO;
      endcase
    end
  endfunction

  // Clock choice for each timer; the wake timer has a fixed source.
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_tmr
      if (gi == W) begin : g_wake
        assign tick[gi] = low_freq_osc_tick_in;
      end else begin : g_gen
        always_comb begin
          case (s_r.ctl[gi][1:0])
            mtu_pkg::CLK_FAST: tick[gi] = fast_tick_in;
            mtu_pkg::CLK_SLOW: tick[gi] = slow_tick_in;
            mtu_pkg::CLK_WAKE: tick[gi] = unf[W];
            default:           tick[gi] = 1'b0;
          endcase
        end
      end
      mtu_chan u_chan (
        .clk_in         (sys_clk_in),
        .rst_n_in       (rst_n),
        .tick_in        (tick[gi]),
        .start_in       (s_r.st_p[gi]),
        .stop_in        (s_r.sp_p[gi]),
        .start_evt_in   (start_evt_in[gi]),
        .stop_evt_in    (stop_evt_in[gi]),
        .wait_evt_in    (s_r.ctl[gi][mtu_pkg::CTL_WAIT_EVT]),
        .stop_evt_en_in (s_r.ctl[gi][mtu_pkg::CTL_STOP_EVT]),
        .auto_reload_in (s_r.ctl[gi][mtu_pkg::CTL_AUTO_REL]),
        .reload_in      (s_r.rel[gi]),
        .count_out      (cnt[gi]),
        .running_out    (run[gi]),
        .underflow_out  (unf[gi])
      );
    end
  endgenerate

  // Bus slave with zero wait states, then register effects of a write.
  logic       take;
  logic       wr;
  logic [2:0] wt;
  logic [N-1:0] fset;
  logic [N-1:0] fclr;
  assign take = hsel_in && htrans_in[1] && hready_in;
  assign wr   = s_r.dph;
  assign wt   = tmr_of(s_r.dadr);

  always_comb begin
    s_nxt = s_r;
    s_nxt.st_p  = '0;
    s_nxt.sp_p  = '0;
    s_nxt.wake  = 1'b0;
    s_nxt.ready = 1'b1;
    s_nxt.dph   = take && hwrite_in;
    s_nxt.dadr  = {haddr_in[7:2], 2'b00};
    fset = '0;
    fclr = '0;
    if (take && !hwrite_in) begin
      s_nxt.rdata = rd_word({haddr_in[7:2], 2'b00}, s_r, cnt, run);
    end
    if (wr) begin
      if (wt != 3'(N)) begin
        case (s_r.dadr[4:2])
          mtu_pkg::OFS_CTL: begin
            s_nxt.ctl[wt] = hwdata_in[mtu_pkg::CTL_W-1:0] & 7'h77;
            s_nxt.st_p[wt] = hwdata_in[mtu_pkg::CTL_START];
          end
          mtu_pkg::OFS_REL_HI: s_nxt.rel[wt][15:8] = hwdata_in[7:0];
          mtu_pkg::OFS_REL_LO: s_nxt.rel[wt][7:0] = hwdata_in[7:0];
          default: s_nxt.dph = s_nxt.dph;
        endcase
      end else begin
        case (s_r.dadr)
          mtu_pkg::ADR_RUN_CTL: begin
            for (int i = 0; i < W; i++) begin
              if (hwdata_in[mtu_pkg::SSN_LSB + i]) begin
                s_nxt.st_p[i] = hwdata_in[i];
                s_nxt.sp_p[i] = !hwdata_in[i];
              end
            end
          end
          mtu_pkg::ADR_IRQ_FLG: begin
            if (hwdata_in[mtu_pkg::FLG_SET_BIT]) begin
              fset = hwdata_in[N-1:0];
            end else begin
              fclr = hwdata_in[N-1:0];
            end
          end
          mtu_pkg::ADR_IRQ_EN: s_nxt.ien = hwdata_in[N-1:0];
          mtu_pkg::ADR_PWR:    s_nxt.stby = hwdata_in[0];
          default:             s_nxt.dph = s_nxt.dph;
        endcase
      end
    end
    // Hardware set beats a software clear landing in the same cycle.
    s_nxt.flg = (s_r.flg & ~fclr) | fset | unf;
    s_nxt.irq = |(s_nxt.flg & s_nxt.ien);
    // Wake timer ends standby; no card sends it back only with auto wake.
    if (unf[W]) begin
      s_nxt.stby = 1'b0;
      s_nxt.wake = 1'b1;
    end else if (card_check_done_in && !card_found_in &&
                 s_r.ctl[W][mtu_pkg::CTL_AUTO_WK]) begin
      s_nxt.stby = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_r.ctl   <= {N{mtu_pkg::CTL_RST}};
      s_r.rel   <= {N{mtu_pkg::REL_RST}};
      s_r.flg   <= '0;
      s_r.ien   <= '0;
      s_r.st_p  <= '0;
      s_r.sp_p  <= '0;
      s_r.stby  <= 1'b0;
      s_r.wake  <= 1'b0;
      s_r.irq   <= 1'b0;
      s_r.dph   <= 1'b0;
      s_r.dadr  <= 8'h00;
      s_r.rdata <= mtu_pkg::RD_ZERO;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Every output but hresp_out, which is tied low, is a flop of the state record.
  assign hrdata_out    = s_r.rdata;
  assign hreadyout_out = s_r.ready;
  assign hresp_out     = 1'b0;
  assign irq_out       = s_r.irq;
  assign standby_out   = s_r.stby;
  assign wake_out      = s_r.wake;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_start_wr(int i);
    wr && s_r.dadr == mtu_pkg::ADR_RUN_CTL && hwdata_in[i] && hwdata_in[i + 4];
  endsequence
  sequence s_stop_wr(int i);
    wr && s_r.dadr == mtu_pkg::ADR_RUN_CTL && !hwdata_in[i] && hwdata_in[i + 4];
  endsequence

  property p_irq(int i);
    unf[i] && s_r.ien[i] |=> irq_out && s_r.flg[i];
  endproperty
  a_irq0: assert property (p_irq(0)) else $error("timer 0 irq missing");
  a_irq3: assert property (p_irq(3)) else $error("timer 3 irq missing");

  property p_setwins;
    unf[1] && wr && s_r.dadr == mtu_pkg::ADR_IRQ_FLG |=> s_r.flg[1];
  endproperty
  a_setwins: assert property (p_setwins) else $error("underflow lost");

  property p_start(int i);
    s_start_wr(i) |=> s_r.st_p[i] ##1 run[i];
  endproperty
  a_start0: assert property (p_start(0)) else $error("start ignored");

  property p_stop(int i);
    s_stop_wr(i) ##1 !s_r.st_p[i] |=> !run[i] [*2];
  endproperty
  a_stop1: assert property (p_stop(1)) else $error("stop ignored");

  property p_rdrun;
    take && !hwrite_in && haddr_in[7:0] == mtu_pkg::ADR_RUN_CTL
      |=> hrdata_out == {27'h0, $past(run)};
  endproperty
  a_rdrun: assert property (p_rdrun) else $error("running bits misread");

  property p_wake;
    unf[W] |=> !standby_out && wake_out ##1 !wake_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not leave standby");

  property p_stay;
    card_check_done_in && !card_found_in && !unf[W] && !wr
      && !s_r.ctl[W][mtu_pkg::CTL_AUTO_WK] |=> standby_out == $past(standby_out);
  endproperty
  a_stay: assert property (p_stay) else $error("standby without auto wake");

  // Software flag writes; a set must stick and a clear must drop the bit.
  property p_flgset(int i);
    wr && s_r.dadr == mtu_pkg::ADR_IRQ_FLG && hwdata_in[mtu_pkg::FLG_SET_BIT] && hwdata_in[i]
      |=> s_r.flg[i];
  endproperty
  a_flgset0: assert property (p_flgset(0)) else $error("flag set lost");
  property p_flgclr(int i);
    wr && s_r.dadr == mtu_pkg::ADR_IRQ_FLG && !hwdata_in[mtu_pkg::FLG_SET_BIT] && hwdata_in[i]
      && !unf[i] |=> !s_r.flg[i];
  endproperty
  a_flgclr1: assert property (p_flgclr(1)) else $error("flag clear lost");

  // A start bit written to a timer's own control acts like the shared start.
  sequence s_ctl_start(int i);
    wr && wt == 3'(i) && s_r.dadr[4:2] == mtu_pkg::OFS_CTL && hwdata_in[mtu_pkg::CTL_START];
  endsequence
  property p_ctlstart(int i);
    s_ctl_start(i) |=> s_r.st_p[i] ##1 run[i];
  endproperty
  a_ctlstart2: assert property (p_ctlstart(2)) else $error("control start ignored");

  // An armed timer ignores its ticks until the start event arrives.
  sequence s_armed(int i);
    s_r.st_p[i] && !s_r.sp_p[i] && s_r.ctl[i][mtu_pkg::CTL_WAIT_EVT]
      ##1 !start_evt_in[i] && !s_r.st_p[i] && !s_r.sp_p[i];
  endsequence
  property p_armed(int i);
    s_armed(i) |=> run[i] && cnt[i] == $past(cnt[i]);
  endproperty
  a_armed2: assert property (p_armed(2)) else $error("armed timer moved");

  // A stopped timer keeps its count so software can still read it.
  property p_freeze(int i);
    !run[i] && !s_r.st_p[i] |=> cnt[i] == $past(cnt[i]);
  endproperty
  a_freeze2: assert property (p_freeze(2)) else $error("stopped count moved");

  // Auto reload keeps the timer running from its reload value.
  property p_period(int i);
    unf[i] && $past(s_r.ctl[i][mtu_pkg::CTL_AUTO_REL])
      |-> run[i] && cnt[i] == $past(s_r.rel[i]);
  endproperty
  a_period1: assert property (p_period(1)) else $error("periodic reload lost");

  // Reload bytes land as written; counter bytes read back as they stand.
  property p_relwr;
    wr && wt == 3'h0 && s_r.dadr[4:2] == mtu_pkg::OFS_REL_LO
      |=> s_r.rel[0][7:0] == $past(hwdata_in[7:0]);
  endproperty
  a_relwr0: assert property (p_relwr) else $error("reload byte lost");
  property p_rdcnt;
    take && !hwrite_in && tmr_of(haddr_in[7:0]) == 3'h0 && haddr_in[4:2] == mtu_pkg::OFS_CNT_LO
      |=> hrdata_out == {24'h0, $past(cnt[0][7:0])};
  endproperty
  a_rdcnt0: assert property (p_rdcnt) else $error("count byte misread");
endmodule

/* File: mtu_top_tb.sv */
`timescale 1ns/1ps
module mtu_top_tb;
  // Bus, strobe and status signals of the unit under test.
  logic        clk        = 1'b0;
  logic        rst_n      = 1'b0;
  logic        hsel       = 1'b0;
  logic        hwrite     = 1'b0;
  logic        card_found = 1'b0;
  logic [1:0]  htrans     = 2'h0;
  logic [31:0] haddr      = 32'h0000_0000;
  logic [31:0] hwdata     = 32'h0000_0000;
  logic [31:0] hrdata;
  logic [31:0] rd_data;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        standby;
  logic        wake;
  // Pulse bundle: done, stop events, start events, oscillator, slow, fast.
  logic [13:0] pulse_r    = 14'h0000;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles     = 0;
  int          wake_cnt   = 0;
  localparam logic [13:0] P_FAST = 14'h0001;
  localparam logic [13:0] P_SLOW = 14'h0002;
  localparam logic [13:0] P_LFO  = 14'h0004;
  localparam logic [13:0] P_DONE = 14'h2000;
  // Ordinary cases: address read after reset beside the value it must give.
  logic [31:0] row_a [8] = '{32'h0000_0000, 32'h0000_0004, 32'h0000_0008, 32'h0000_000c,
                             32'h0000_0024, 32'h0000_0028, 32'h0000_0030, 32'h0000_0010};
  logic [31:0] row_e [8] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                             32'h0000_00ff, 32'h0000_00ff, 32'h0000_0000, 32'h0000_0000};

  mtu_top mtu_top_inst (
    .sys_clk_in           (clk),
    .arst_n_in            (rst_n),
    .hsel_in              (hsel),
    .haddr_in             (haddr),
    .htrans_in            (htrans),
    .hwrite_in            (hwrite),
    .hsize_in             (3'h2),
    .hwdata_in            (hwdata),
    .hready_in            (hreadyout),
    .hrdata_out           (hrdata),
    .hreadyout_out        (hreadyout),
    .hresp_out            (hresp),
    .fast_tick_in         (pulse_r[0]),
    .slow_tick_in         (pulse_r[1]),
    .low_freq_osc_tick_in (pulse_r[2]),
    .start_evt_in         (pulse_r[7:3]),
    .stop_evt_in          (pulse_r[12:8]),
    .card_check_done_in   (pulse_r[13]),
    .card_found_in        (card_found),
    .irq_out              (irq),
    .standby_out          (standby),
    .wake_out             (wake)
  );

  // Free-running 10 MHz clock.
  always #50 clk = ~clk;

  // Wake pulses last one cycle, so they are counted here rather than polled.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wake === 1'b1) begin
      wake_cnt <= wake_cnt + 1;
    end
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      close_out();
    end
  end

  // Verdict and end of run.
  task automatic close_out();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compare tasks, one per kind of result.
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single-word transfer; hangs are cut by the cycle ceiling above.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd_data = hrdata;
    // Idle gap lets timer commands reach the counters before the next access.
    repeat (3) @(posedge clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk_word(rd_data, exp);
  endtask

  // One-cycle pulse on the selected strobes, then settling time.
  task automatic pls(input logic [13:0] v);
    @(posedge clk);
    pulse_r <= v;
    @(posedge clk);
    pulse_r <= 14'h0000;
    repeat (3) @(posedge clk);
  endtask

  // Byte address of a register in the window of timer i.
  function automatic logic [31:0] ta(input int i, input logic [2:0] o);
    return 32'(mtu_pkg::TMR_STRIDE) * (i + 1) + 32'(o) * 4;
  endfunction

  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    chk_bit(hreadyout, 1'b1);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int r = 0; r < 8; r++) begin
      rd(row_a[r], row_e[r]);
    end
    chk_bit(hresp, 1'b0);
    // One-shot on timer 0 from the fast clock.
    wr(32'h0000_0008, 32'h0000_001f);
    wr(ta(0, 1), 32'h0000_0000);
    wr(ta(0, 2), 32'h0000_0003);
    wr(32'h0000_0000, 32'h0000_0011);
    rd(32'h0000_0000, 32'h0000_0001);
    rd(ta(0, 4), 32'h0000_0003);
    pls(P_FAST);
    rd(ta(0, 4), 32'h0000_0002);
    pls(P_FAST);
    pls(P_FAST);
    rd(ta(0, 4), 32'h0000_0000);
    chk_bit(irq, 1'b0);
    pls(P_FAST);
    chk_bit(irq, 1'b1);
    rd(32'h0000_0004, 32'h0000_0001);
    rd(32'h0000_0000, 32'h0000_0000);
    rd(ta(0, 4), 32'h0000_0000);
    wr(32'h0000_0008, 32'h0000_0000);
    chk_bit(irq, 1'b0);
    wr(32'h0000_0008, 32'h0000_001f);
    wr(32'h0000_0004, 32'h0000_0001);
    chk_bit(irq, 1'b0);
    wr(32'h0000_0004, 32'h0000_0081);
    rd(32'h0000_0004, 32'h0000_0001);
    wr(32'h0000_0004, 32'h0000_0001);
    // Periodic timer 1 on the slow clock, started from its own control.
    wr(ta(1, 1), 32'h0000_0000);
    wr(ta(1, 2), 32'h0000_0001);
    wr(ta(1, 0), 32'h0000_000d);
    rd(32'h0000_0000, 32'h0000_0002);
    pls(P_FAST);
    rd(ta(1, 4), 32'h0000_0001);
    pls(P_SLOW);
    pls(P_SLOW);
    rd(32'h0000_0004, 32'h0000_0002);
    rd(ta(1, 4), 32'h0000_0001);
    wr(32'h0000_0004, 32'h0000_0002);
    pls(P_SLOW);
    pls(P_SLOW);
    rd(32'h0000_0004, 32'h0000_0002);
    wr(32'h0000_0004, 32'h0000_0002);
    wr(32'h0000_0000, 32'h0000_0020);
    rd(32'h0000_0000, 32'h0000_0000);
    pls(P_SLOW);
    rd(ta(1, 4), 32'h0000_0001);
    // Time-out on timer 2 gated by start and stop events.
    wr(ta(2, 1), 32'h0000_0000);
    wr(ta(2, 2), 32'h0000_0005);
    wr(ta(2, 0), 32'h0000_0038);
    rd(32'h0000_0000, 32'h0000_0004);
    pls(P_FAST);
    rd(ta(2, 4), 32'h0000_0005);
    pls(14'h0020);
    pls(P_FAST);
    rd(ta(2, 4), 32'h0000_0004);
    pls(14'h0400);
    rd(32'h0000_0000, 32'h0000_0000);
    pls(P_FAST);
    // Elapsed ticks are reload minus frozen count, valid only while the flag is clear.
    rd(ta(2, 4), 32'h0000_0004);
    rd(32'h0000_0004, 32'h0000_0000);
    // Wake timer cycling standby, timer 3 counting its underflows.
    wr(32'h0000_000c, 32'h0000_0001);
    chk_bit(standby, 1'b1);
    wr(ta(4, 1), 32'h0000_0000);
    wr(ta(4, 2), 32'h0000_0000);
    wr(ta(3, 1), 32'h0000_0000);
    wr(ta(3, 2), 32'h0000_0002);
    wr(ta(3, 0), 32'h0000_000a);
    wr(ta(4, 0), 32'h0000_004c);
    rd(32'h0000_0000, 32'h0000_0018);
    pls(P_LFO);
    chk_word(32'(wake_cnt), 32'h0000_0001);
    chk_bit(standby, 1'b0);
    rd(ta(3, 4), 32'h0000_0001);
    rd(32'h0000_0004, 32'h0000_0010);
    pls(P_DONE);
    chk_bit(standby, 1'b1);
    wr(ta(4, 0), 32'h0000_0004);
    pls(P_LFO);
    chk_word(32'(wake_cnt), 32'h0000_0002);
    chk_bit(standby, 1'b0);
    pls(P_DONE);
    chk_bit(standby, 1'b0);
    rd(ta(3, 4), 32'h0000_0000);
    // Third wake underflow drives timer 3 through zero, so it flags too.
    pls(P_LFO);
    chk_word(32'(wake_cnt), 32'h0000_0003);
    rd(32'h0000_0004, 32'h0000_0018);
    // Reset in mid-run returns every register to its reset value again.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk_bit(hreadyout, 1'b1);
    chk_bit(irq, 1'b0);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(32'h0000_0000, 32'h0000_0000);
    rd(ta(0, 1), 32'h0000_00ff);
    close_out();
  end
endmodule
